/* File: aoc_pkg.sv */
`default_nettype none

package aoc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [6:0] AOC_ADDR_RESET_READOUT = 7'h00;
    localparam logic [6:0] AOC_ADDR_CLK_DRIVE     = 7'h10;
    localparam logic [6:0] AOC_ADDR_CURRENT_DRIVE = 7'h11;
    localparam logic [6:0] AOC_ADDR_TERMINATION   = 7'h12;
    localparam logic [6:0] AOC_ADDR_OFFSET_HOLD   = 7'h13;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int AOC_BIT_READOUT_DIS = 0;
    localparam int AOC_BIT_SOFT_RESET  = 1;
    localparam int AOC_CLK_DRIVE_LSB   = 6;
    localparam int AOC_DATA_DRIVE_LSB  = 0;
    localparam int AOC_CURRENT_LSB     = 2;
    localparam int AOC_DOUBLE_LSB      = 4;
    localparam int AOC_DATA_TERM_LSB   = 3;
    localparam int AOC_CLK_TERM_LSB    = 0;
    localparam int AOC_FREEZE_BIT      = 4;

    // ------------------------------------------------------------
    // Writable bits of each register (the rest hold zero)
    // ------------------------------------------------------------
    localparam logic [7:0] AOC_MASK_RESET_READOUT = 8'h01;
    localparam logic [7:0] AOC_MASK_CLK_DRIVE     = 8'hc0;
    localparam logic [7:0] AOC_MASK_CURRENT_DRIVE = 8'h3f;
    localparam logic [7:0] AOC_MASK_TERMINATION   = 8'h3f;
    localparam logic [7:0] AOC_MASK_OFFSET_HOLD   = 8'h10;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] AOC_RST_RESET_READOUT  = 8'h00;
    localparam logic [7:0] AOC_RST_CLK_DRIVE      = 8'h00;
    localparam logic [7:0] AOC_RST_CURRENT_DRIVE  = 8'h00;
    localparam logic [7:0] AOC_RST_TERMINATION    = 8'h00;
    localparam logic [7:0] AOC_RST_OFFSET_HOLD    = 8'h00;

    // ------------------------------------------------------------
    // Serial frame layout
    // ------------------------------------------------------------
    localparam logic [4:0] AOC_LAST_ADDR_BIT = 5'h07;
    localparam logic [4:0] AOC_LAST_BIT      = 5'h0f;
    localparam int         AOC_READ_FLAG_BIT = 7;

    // Drive strength codes
    typedef enum logic [1:0] {
        AOC_DRIVE_DEFAULT  = 2'b00,
        AOC_DRIVE_WEAKER   = 2'b01,
        AOC_DRIVE_MAXIMUM  = 2'b10,
        AOC_DRIVE_STRONGER = 2'b11
    } aoc_drive_e;

    // Current doubling codes
    typedef enum logic [1:0] {
        AOC_DOUBLE_NONE   = 2'b00,
        AOC_DOUBLE_CLK    = 2'b01,
        AOC_DOUBLE_ALL    = 2'b10,
        AOC_DOUBLE_UNUSED = 2'b11
    } aoc_double_e;

    // Serial frame phases
    typedef enum logic [1:0] {
        AOC_FR_IDLE = 2'b00,
        AOC_FR_ADDR = 2'b01,
        AOC_FR_DATA = 2'b10,
        AOC_FR_DONE = 2'b11
    } aoc_frame_e;

endpackage

`default_nettype wire

/* File: aoc_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module aoc_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta;

    // Two stages; the first is read only by the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else if (ce_i) begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end

endmodule // aoc_sync

`default_nettype wire

/* File: aoc_output_config.sv */
`timescale 1ns/100ps
`default_nettype none

module aoc_output_config
    import aoc_pkg::*;
#(
    parameter int SAMPLE_W  = 11,
    parameter int EST_SHIFT = 4
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       ce_i,
    input  wire logic                       serial_en_n_i,
    input  wire logic                       serial_clk_i,
    input  wire logic                       serial_data_i,
    output logic                            serial_out_pin_o,
    input  wire logic signed [SAMPLE_W-1:0] sample_i,
    input  wire logic                       sample_valid_i,
    output logic signed [SAMPLE_W-1:0]      corrected_o,
    output logic                            corrected_valid_o,
    output logic signed [SAMPLE_W-1:0]      offset_est_o,
    output aoc_drive_e                      clk_drive_o,
    output aoc_drive_e                      data_drive_o,
    output logic [1:0]                      lvds_current_o,
    output aoc_double_e                     current_double_o,
    output logic [2:0]                      data_term_o,
    output logic [2:0]                      clk_term_o,
    output logic                            offset_freeze_o,
    output logic                            readout_disable_o
);

    // ------------------------------------------------------------
    // Register read decode
    // ------------------------------------------------------------
    logic [7:0] reset_and_readout_ctrl;
    logic [7:0] clock_out_drive_ctrl;
    logic [7:0] output_current_and_drive_ctrl;
    logic [7:0] output_termination_ctrl;
    logic [7:0] offset_hold_ctrl;

    // Unmapped offsets read zero
    function automatic logic [7:0] read_reg(input logic [6:0] addr);
        case (addr)
            AOC_ADDR_RESET_READOUT: read_reg = reset_and_readout_ctrl;
            AOC_ADDR_CLK_DRIVE:     read_reg = clock_out_drive_ctrl;
            AOC_ADDR_CURRENT_DRIVE: read_reg = output_current_and_drive_ctrl;
            AOC_ADDR_TERMINATION:   read_reg = output_termination_ctrl;
            AOC_ADDR_OFFSET_HOLD:   read_reg = offset_hold_ctrl;
            default:                read_reg = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisation and clock edges
    // ------------------------------------------------------------
    logic [2:0] pins_sync;
    logic       en_n_s;
    logic       sclk_s;
    logic       sdata_s;
    logic       sclk_q;
    logic       sclk_rise;
    logic       sclk_fall;

    aoc_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .async_i ({serial_en_n_i, serial_clk_i, serial_data_i}),
        .sync_o  (pins_sync)
    );

    assign en_n_s  = pins_sync[2];
    assign sclk_s  = pins_sync[1];
    assign sdata_s = pins_sync[0];

    // Edge detect works on synchronised levels only
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_q <= 1'b0;
        end else if (ce_i) begin
            sclk_q <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_q & ~en_n_s;
    assign sclk_fall = ~sclk_s & sclk_q & ~en_n_s;

    // ------------------------------------------------------------
    // Serial frame receiver
    // ------------------------------------------------------------
    aoc_frame_e  frame_state;
    aoc_frame_e  next_frame_state;
    logic [4:0]  bit_cnt;
    logic [14:0] shift_in;
    logic [15:0] next_word;
    logic [7:0]  frame_addr;
    logic        wr_fire;
    logic        addr_done;

    assign next_word  = {shift_in, sdata_s};
    assign frame_addr = shift_in[14:7];
    assign addr_done  = sclk_rise && (frame_state == AOC_FR_ADDR) && (bit_cnt == AOC_LAST_ADDR_BIT);
    // Address bit 7 marks a read; such frames never write
    assign wr_fire    = sclk_rise && (frame_state == AOC_FR_DATA) && (bit_cnt == AOC_LAST_BIT)
                        && !frame_addr[AOC_READ_FLAG_BIT];

    // Frame phase; a rising select aborts any partial frame
    always_comb begin
        next_frame_state = frame_state;
        case (frame_state)
            AOC_FR_IDLE: begin
                if (!en_n_s) begin
                    next_frame_state = AOC_FR_ADDR;
                end
            end
            AOC_FR_ADDR: begin
                if (en_n_s) begin
                    next_frame_state = AOC_FR_IDLE;
                end else if (addr_done) begin
                    next_frame_state = AOC_FR_DATA;
                end
            end
            AOC_FR_DATA: begin
                if (en_n_s) begin
                    next_frame_state = AOC_FR_IDLE;
                end else if (sclk_rise && bit_cnt == AOC_LAST_BIT) begin
                    next_frame_state = AOC_FR_DONE;
                end
            end
            AOC_FR_DONE: begin
                if (en_n_s) begin
                    next_frame_state = AOC_FR_IDLE;
                end
            end
            default: next_frame_state = AOC_FR_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_state <= AOC_FR_IDLE;
        end else if (ce_i) begin
            frame_state <= next_frame_state;
        end
    end

    // Bit counter and input shifter, MSB first
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_cnt  <= 5'h00;
            shift_in <= 15'h0000;
        end else if (ce_i) begin
            if (en_n_s) begin
                bit_cnt <= 5'h00;
            end else if (sclk_rise && frame_state != AOC_FR_DONE) begin
                bit_cnt  <= bit_cnt + 5'h01;
                shift_in <= next_word[14:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------
    logic soft_reset;

    // Reset bit is never stored, so it reads back zero after the write
    assign soft_reset = wr_fire && (frame_addr[6:0] == AOC_ADDR_RESET_READOUT)
                        && next_word[AOC_BIT_SOFT_RESET];

    // Whole-byte writes, masked to the defined fields
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reset_and_readout_ctrl        <= AOC_RST_RESET_READOUT;
            clock_out_drive_ctrl          <= AOC_RST_CLK_DRIVE;
            output_current_and_drive_ctrl <= AOC_RST_CURRENT_DRIVE;
            output_termination_ctrl       <= AOC_RST_TERMINATION;
            offset_hold_ctrl              <= AOC_RST_OFFSET_HOLD;
        end else if (ce_i) begin
            if (soft_reset) begin
                reset_and_readout_ctrl        <= AOC_RST_RESET_READOUT;
                clock_out_drive_ctrl          <= AOC_RST_CLK_DRIVE;
                output_current_and_drive_ctrl <= AOC_RST_CURRENT_DRIVE;
                output_termination_ctrl       <= AOC_RST_TERMINATION;
                offset_hold_ctrl              <= AOC_RST_OFFSET_HOLD;
            end else if (wr_fire) begin
                case (frame_addr[6:0])
                    AOC_ADDR_RESET_READOUT: reset_and_readout_ctrl <= next_word[7:0] & AOC_MASK_RESET_READOUT;
                    AOC_ADDR_CLK_DRIVE:     clock_out_drive_ctrl <= next_word[7:0] & AOC_MASK_CLK_DRIVE;
                    AOC_ADDR_CURRENT_DRIVE: output_current_and_drive_ctrl <= next_word[7:0] & AOC_MASK_CURRENT_DRIVE;
                    AOC_ADDR_TERMINATION:   output_termination_ctrl <= next_word[7:0] & AOC_MASK_TERMINATION;
                    AOC_ADDR_OFFSET_HOLD:   offset_hold_ctrl <= next_word[7:0] & AOC_MASK_OFFSET_HOLD;
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration outputs
    // ------------------------------------------------------------
    // Registered copies keep outputs on flops and apply one write as a unit
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_drive_o       <= AOC_DRIVE_DEFAULT;
            data_drive_o      <= AOC_DRIVE_DEFAULT;
            lvds_current_o    <= 2'h0;
            current_double_o  <= AOC_DOUBLE_NONE;
            data_term_o       <= 3'h0;
            clk_term_o        <= 3'h0;
            offset_freeze_o   <= 1'b0;
            readout_disable_o <= 1'b0;
        end else if (ce_i) begin
            clk_drive_o       <= aoc_drive_e'(clock_out_drive_ctrl[AOC_CLK_DRIVE_LSB +: 2]);
            data_drive_o      <= aoc_drive_e'(output_current_and_drive_ctrl[AOC_DATA_DRIVE_LSB +: 2]);
            lvds_current_o    <= output_current_and_drive_ctrl[AOC_CURRENT_LSB +: 2];
            current_double_o  <= aoc_double_e'(output_current_and_drive_ctrl[AOC_DOUBLE_LSB +: 2]);
            data_term_o       <= output_termination_ctrl[AOC_DATA_TERM_LSB +: 3];
            clk_term_o        <= output_termination_ctrl[AOC_CLK_TERM_LSB +: 3];
            offset_freeze_o   <= offset_hold_ctrl[AOC_FREEZE_BIT];
            readout_disable_o <= reset_and_readout_ctrl[AOC_BIT_READOUT_DIS];
        end
    end

    // ------------------------------------------------------------
    // Serial readout
    // ------------------------------------------------------------
    logic [7:0] rd_shift;

    // Load after the address byte, shift on falling serial clock
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_shift         <= 8'h00;
            serial_out_pin_o <= 1'b0;
        end else if (ce_i) begin
            if (reset_and_readout_ctrl[AOC_BIT_READOUT_DIS] || en_n_s) begin
                serial_out_pin_o <= 1'b0;
            end else if (addr_done) begin
                rd_shift <= read_reg(next_word[6:0]);
            end else if (sclk_fall && frame_state == AOC_FR_DATA) begin
                serial_out_pin_o <= rd_shift[7];
                rd_shift         <= {rd_shift[6:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------
    // Offset estimation and cancellation
    // ------------------------------------------------------------
    logic signed [SAMPLE_W-1:0] est_err;

    // First-order tracking; a bigger shift trades settling time for noise
    assign est_err = sample_i - offset_est_o;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            offset_est_o <= '0;
        end else if (ce_i) begin
            if (sample_valid_i && !offset_hold_ctrl[AOC_FREEZE_BIT]) begin
                offset_est_o <= offset_est_o + (est_err >>> EST_SHIFT);
            end
        end
    end

    // Cancellation keeps running with the held estimate while frozen
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            corrected_o       <= '0;
            corrected_valid_o <= 1'b0;
        end else if (ce_i) begin
            corrected_valid_o <= sample_valid_i;
            if (sample_valid_i) begin
                corrected_o <= sample_i - offset_est_o;
            end
        end
    end

endmodule // aoc_output_config

`default_nettype wire

/* File: aoc_output_config_props.sv */
`timescale 1ns/100ps
`default_nettype none

module aoc_output_config_props
    import aoc_pkg::*;
#(
    parameter int SAMPLE_W  = 11,
    parameter int EST_SHIFT = 4
) (
    input wire logic                       clk_i,
    input wire logic                       rst_n_i,
    input wire logic                       serial_en_n_i,
    input wire logic                       serial_out_pin_o,
    input wire logic signed [SAMPLE_W-1:0] sample_i,
    input wire logic                       sample_valid_i,
    input wire logic signed [SAMPLE_W-1:0] corrected_o,
    input wire logic                       corrected_valid_o,
    input wire logic signed [SAMPLE_W-1:0] offset_est_o,
    input wire aoc_drive_e                 clk_drive_o,
    input wire aoc_drive_e                 data_drive_o,
    input wire logic [1:0]                 lvds_current_o,
    input wire aoc_double_e                current_double_o,
    input wire logic [2:0]                 data_term_o,
    input wire logic [2:0]                 clk_term_o,
    input wire logic                       offset_freeze_o,
    input wire logic                       readout_disable_o
);
    // ------------------------------------------------------------
    // Grouped views of the configuration outputs
    // ------------------------------------------------------------
    logic [5:0]  cur_grp;
    logic [15:0] cfg_all;
    assign cur_grp = {data_drive_o, lvds_current_o, current_double_o};
    assign cfg_all = {clk_drive_o, cur_grp, data_term_o, clk_term_o, offset_freeze_o, readout_disable_o};

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // Pin is never left showing readout data once readout is off
    AST_RO_PIN_LOW: assert property (readout_disable_o [*3] |-> !serial_out_pin_o)
        else $error("serial pin not low while readout disabled");
    AST_PIN_IDLE: assert property (serial_en_n_i [*5] |-> !serial_out_pin_o)
        else $error("serial pin active while deselected");
    // Staggered field updates would show as a second change shortly after
    AST_CFG_TOGETHER: assert property (!$stable(cur_grp) |=> $stable(cur_grp) [*4])
        else $error("fields of one register changed apart");
    AST_CFG_QUIET: assert property (serial_en_n_i [*8] |-> $stable(cfg_all))
        else $error("configuration changed without a write");
    AST_CORR_VALID: assert property (1'b1 |=> corrected_valid_o == $past(sample_valid_i))
        else $error("corrected strobe not one cycle after sample");
    AST_CORR_VALUE: assert property (sample_valid_i |=>
        corrected_o == SAMPLE_W'($past(sample_i) - $past(offset_est_o)))
        else $error("corrected value wrong");
    AST_EST_STEP: assert property (sample_valid_i && !offset_freeze_o ##1 !offset_freeze_o |->
        offset_est_o == SAMPLE_W'($past(offset_est_o) + (($past(sample_i) - $past(offset_est_o)) >>> EST_SHIFT)))
        else $error("estimate step wrong");
    AST_EST_FROZEN: assert property (offset_freeze_o && $past(offset_freeze_o) |-> $stable(offset_est_o))
        else $error("estimate moved while frozen");
    AST_EST_IDLE: assert property (!sample_valid_i |=> $stable(offset_est_o))
        else $error("estimate moved without a sample");

    COV_READ_DISABLED: cover property (readout_disable_o && !serial_en_n_i);
    COV_FROZEN_SAMPLE: cover property (sample_valid_i && offset_freeze_o);
    COV_PIN_HIGH: cover property ($rose(serial_out_pin_o));
endmodule // aoc_output_config_props

bind aoc_output_config aoc_output_config_props #(.SAMPLE_W(SAMPLE_W), .EST_SHIFT(EST_SHIFT))
aoc_output_config_props_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .serial_en_n_i(serial_en_n_i), .serial_out_pin_o(serial_out_pin_o),
    .sample_i(sample_i), .sample_valid_i(sample_valid_i), .corrected_o(corrected_o),
    .corrected_valid_o(corrected_valid_o), .offset_est_o(offset_est_o), .clk_drive_o(clk_drive_o),
    .data_drive_o(data_drive_o), .lvds_current_o(lvds_current_o), .current_double_o(current_double_o),
    .data_term_o(data_term_o), .clk_term_o(clk_term_o), .offset_freeze_o(offset_freeze_o),
    .readout_disable_o(readout_disable_o)
);

`default_nettype wire

/* File: aoc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// Host on the serial control port; every pin moves on the falling clk edge
module aoc_host_model #(
    parameter int HALF = 6
) (
    input  wire logic clk_i,
    input  wire logic serial_out_pin_i,
    output var logic  serial_en_n_o,
    output var logic  serial_clk_o,
    output var logic  serial_data_o
);
    // Idle: deselected, serial clock parked low
    initial begin
        serial_en_n_o = 1'b1;
        serial_clk_o  = 1'b0;
        serial_data_o = 1'b0;
    end

    // One 16-bit frame, MSB first; HALF must exceed the 2-flop sync plus one
    task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
        rd = 8'h00;
        @(negedge clk_i);
        serial_en_n_o = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            serial_data_o = frame[i];
            repeat (HALF) @(negedge clk_i);
            serial_clk_o = 1'b1;
            if (i < 8) begin
                rd = {rd[6:0], serial_out_pin_i};
            end
            repeat (HALF) @(negedge clk_i);
            serial_clk_o = 1'b0;
        end
        repeat (HALF) @(negedge clk_i);
        serial_en_n_o = 1'b1;
        serial_data_o = ~serial_data_o; // Released line must not keep its last value
        repeat (HALF) @(negedge clk_i);
    endtask
endmodule // aoc_host_model

`default_nettype wire

/* File: aoc_output_config_test.sv */
`timescale 1ns/100ps
`default_nettype none

`define CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); end end

module aoc_output_config_test
    import aoc_pkg::*;
();
    localparam int SW    = 11;
    localparam int LIMIT = 40000;
    logic                 clk_i          = 1'b0;
    logic                 rst_n_i        = 1'b0;
    logic                 ce_i           = 1'b1;
    logic signed [SW-1:0] sample_i       = '0;
    logic                 sample_valid_i = 1'b0;
    logic                 serial_en_n_i, serial_clk_i, serial_data_i, serial_out_pin_o;
    logic signed [SW-1:0] corrected_o, offset_est_o;
    logic                 corrected_valid_o, offset_freeze_o, readout_disable_o;
    aoc_drive_e           clk_drive_o, data_drive_o;
    aoc_double_e          current_double_o;
    logic [1:0]           lvds_current_o;
    logic [2:0]           data_term_o, clk_term_o;
    logic [7:0]           mreg [0:127];
    logic [7:0]           got;
    logic [6:0]           addr;
    int                   fail_count = 0, checked = 0, cycles = 0, seed = 58, est = 0;

    aoc_output_config #(.SAMPLE_W(SW), .EST_SHIFT(4)) aoc_output_config_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .serial_en_n_i(serial_en_n_i),
        .serial_clk_i(serial_clk_i), .serial_data_i(serial_data_i), .serial_out_pin_o(serial_out_pin_o),
        .sample_i(sample_i), .sample_valid_i(sample_valid_i), .corrected_o(corrected_o),
        .corrected_valid_o(corrected_valid_o), .offset_est_o(offset_est_o), .clk_drive_o(clk_drive_o),
        .data_drive_o(data_drive_o), .lvds_current_o(lvds_current_o), .current_double_o(current_double_o),
        .data_term_o(data_term_o), .clk_term_o(clk_term_o), .offset_freeze_o(offset_freeze_o),
        .readout_disable_o(readout_disable_o));

    aoc_host_model #(.HALF(6)) aoc_host_model_inst (
        .clk_i(clk_i), .serial_out_pin_i(serial_out_pin_o), .serial_en_n_o(serial_en_n_i),
        .serial_clk_o(serial_clk_i), .serial_data_o(serial_data_i));

    // Clock and hang guard; the ceiling is about three times the expected run
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (fail_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    function automatic logic [7:0] mask_of(input logic [6:0] a);
        case (a)
            AOC_ADDR_RESET_READOUT: return AOC_MASK_RESET_READOUT;
            AOC_ADDR_CLK_DRIVE:     return AOC_MASK_CLK_DRIVE;
            AOC_ADDR_CURRENT_DRIVE: return AOC_MASK_CURRENT_DRIVE;
            AOC_ADDR_TERMINATION:   return AOC_MASK_TERMINATION;
            AOC_ADDR_OFFSET_HOLD:   return AOC_MASK_OFFSET_HOLD;
            default:                return 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Model comparisons
    // ------------------------------------------------------------
    task automatic check_outputs();
        `CHECK(clk_drive_o, mreg[7'h10][7:6])
        `CHECK(data_drive_o, mreg[7'h11][1:0])
        `CHECK(lvds_current_o, mreg[7'h11][3:2])
        `CHECK(current_double_o, mreg[7'h11][5:4])
        `CHECK(data_term_o, mreg[7'h12][5:3])
        `CHECK(clk_term_o, mreg[7'h12][2:0])
        `CHECK(offset_freeze_o, mreg[7'h13][4])
        `CHECK(readout_disable_o, mreg[7'h00][0])
    endtask

    // Soft reset wins over the other bits of the same write
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        aoc_host_model_inst.xfer({1'b0, a, d}, got);
        if (a == AOC_ADDR_RESET_READOUT && d[AOC_BIT_SOFT_RESET]) begin
            foreach (mreg[k]) mreg[k] = 8'h00;
        end else begin
            mreg[a] = d & mask_of(a);
        end
        check_outputs();
    endtask

    task automatic rd_chk(input logic [6:0] a);
        aoc_host_model_inst.xfer({1'b1, a, 8'h00}, got);
        `CHECK(got, mreg[7'h00][0] ? 8'h00 : mreg[a])
    endtask

    // Valid is left high so samples can run back to back
    task automatic put_sample(input int s);
        sample_i = SW'(s);
        sample_valid_i = 1'b1;
        @(negedge clk_i);
        `CHECK(corrected_valid_o, 1'b1)
        `CHECK(corrected_o, SW'(s - est))
        if (!mreg[7'h13][4]) est = est + ((s - est) >>> 4);
        `CHECK(offset_est_o, SW'(est))
    endtask

    initial begin
        foreach (mreg[k]) mreg[k] = 8'h00;
        repeat (2) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        check_outputs();
        // Every code of the drive, current and termination fields
        for (int i = 0; i < 8; i++) begin
            wr(AOC_ADDR_CLK_DRIVE, 8'(i << 6));
            wr(AOC_ADDR_CURRENT_DRIVE, 8'(i * 9));
            wr(AOC_ADDR_TERMINATION, 8'((i << 3) | (7 - i)));
            rd_chk(AOC_ADDR_TERMINATION);
        end
        for (int i = 0; i < 10; i++) begin
            addr = 7'h10 + 7'($unsigned($random(seed)) % 4);
            wr(addr, 8'($random(seed)) & mask_of(addr));
            rd_chk(addr);
        end
        wr(7'h05, 8'hff);
        rd_chk(7'h05);
        rd_chk(AOC_ADDR_CURRENT_DRIVE);
        // Estimator free, frozen, then free again
        for (int p = 0; p < 3; p++) begin
            wr(AOC_ADDR_OFFSET_HOLD, (p == 1) ? 8'h10 : 8'h00);
            for (int i = 0; i < 20; i++) begin
                put_sample(120 + $random(seed) % 50);
                if ($random(seed) & 1) begin
                    sample_valid_i = 1'b0;
                    @(negedge clk_i);
                end
            end
            sample_valid_i = 1'b0;
        end
        wr(AOC_ADDR_RESET_READOUT, 8'h01);
        rd_chk(AOC_ADDR_TERMINATION);
        wr(AOC_ADDR_RESET_READOUT, 8'h00);
        rd_chk(AOC_ADDR_TERMINATION);
        wr(AOC_ADDR_RESET_READOUT, 8'h03);
        rd_chk(AOC_ADDR_RESET_READOUT);
        for (int i = 0; i < 4; i++) rd_chk(7'h10 + 7'(i));
        stop_test();
    end
endmodule // aoc_output_config_test

`undef CHECK
`default_nettype wire
